//--- design/gac_control.sv
/*
 * Converter control: regulator settle status, sampling and conversion
 * sequencing, self-clearing start bit, chop averaging, dummy loads and
 * the result register.
 * Assumes software holds its control bits in ctrl and pulses
 * start_write for one cycle when it writes one to the start bit.
 */
`timescale 1ns/1ps
`default_nettype none
module gac_control
    import gac_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire gac_ctrl_t         ctrl,
    input  wire logic              start_write,
    input  wire gac_level_t        pin_level [N_PINS],
    input  wire gac_level_t        battery_level,
    input  wire gac_level_t        internal_level [N_INTERNAL],
    output logic                   conversion_start,
    output logic [CODE_W-1:0]      conversion_result,
    output logic                   result_ready,
    output logic                   regulator_settled,
    output logic                   sampling_active,
    output logic                   converter_hold,
    output logic                   constant_load_on,
    output logic                   sampling_load_on,
    output logic                   attenuator_on
);
    gac_state_t          state;
    gac_state_t          next_state;
    logic [SETTLE_W-1:0] settle_count;
    logic [LEVEL_W-1:0]  pos_level;
    logic [LEVEL_W-1:0]  neg_level;
    logic                single_ended;
    logic                second_half;
    logic                invert_now;
    logic [CODE_W-1:0]   trim_now;
    logic [CODE_W-1:0]   core_code;
    logic [CODE_W-1:0]   first_code;
    logic [CODE_W:0]     chop_sum;
    logic                done;
    logic                powered;
    logic                muted_mid;

    gac_input_mux u_mux (
        .ctrl           (ctrl),
        .pin_level      (pin_level),
        .battery_level  (battery_level),
        .internal_level (internal_level),
        .pos_level      (pos_level),
        .neg_level      (neg_level),
        .single_ended   (single_ended),
        .attenuate      (attenuator_on)
    );

    // Second chop sample runs with the opposite polarity
    assign second_half = (state == ST_CHOP2);
    assign invert_now = ctrl.polarity_invert ^ second_half; // see [R12]
    assign trim_now = invert_now ? ctrl.negative_offset_trim
                                 : ctrl.positive_offset_trim; // see [R17]

    gac_convert_core u_core (
        .pos_level    (pos_level),
        .neg_level    (neg_level),
        .single_ended (single_ended),
        .attenuate    (attenuator_on),
        .mute         (ctrl.input_mute_midscale),
        .invert       (invert_now),
        .trim         (trim_now),
        .code         (core_code)
    );

    assign powered = ctrl.converter_regulator_enable
                   && ctrl.converter_enable;
    assign done = (state == ST_CONVERT && !ctrl.chop_enable)
               || state == ST_CHOP2; // see [R09]
    assign chop_sum = {1'b0, first_code} + {1'b0, core_code};
    assign muted_mid = ctrl.input_mute_midscale
                    && ctrl.positive_offset_trim == CODE_MID
                    && ctrl.negative_offset_trim == CODE_MID;

    // Regulator settle status for software polling
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            settle_count <= '0;
        end else if (!ctrl.converter_regulator_enable) begin
            settle_count <= '0;
        end else if (!regulator_settled) begin
            settle_count <= settle_count + 1'b1; // see [R05]
        end
    end
    assign regulator_settled =
        (settle_count == SETTLE_W'(SETTLE_CYCLES));

    // Phase sequencing
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (powered) begin
                    next_state = ST_SAMPLE; // see [R06]
                end
            end
            ST_SAMPLE: begin
                if (conversion_start) begin
                    next_state = ST_CONVERT; // see [R07]
                end
            end
            ST_CONVERT: begin
                next_state = ctrl.chop_enable ? ST_CHOP2
                                              : ST_SAMPLE; // see [R08]
            end
            ST_CHOP2: begin
                next_state = ST_SAMPLE; // see [R08]
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
        if (!powered) begin
            next_state = ST_OFF;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Start bit: a new write beats the self-clear
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            conversion_start <= 1'b0;
        end else if (start_write && state != ST_OFF) begin
            conversion_start <= 1'b1; // see [R07]
        end else if (done || state == ST_OFF) begin
            conversion_start <= 1'b0; // see [R08]
        end
    end

    // First chop sample
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            first_code <= RESULT_RESET;
        end else if (state == ST_CONVERT) begin
            first_code <= core_code;
        end
    end

    // Result register and completion pulse
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            conversion_result <= RESULT_RESET;
            result_ready <= 1'b0;
        end else begin
            result_ready <= done;
            if (done) begin
                conversion_result <= second_half
                    ? chop_sum[CODE_W:1] : core_code; // see [R19] see [R12]
            end
        end
    end

    assign sampling_active = (state == ST_SAMPLE); // see [R06]
    assign converter_hold = (state == ST_CONVERT) || second_half;
    assign constant_load_on = ctrl.constant_dummy_load
                            && ctrl.converter_regulator_enable; // see [R10]
    assign sampling_load_on = ctrl.sampling_dummy_load
                            && sampling_active; // see [R11]

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_chop_pair;
        state == ST_CONVERT && ctrl.chop_enable ##1 state == ST_CHOP2;
    endsequence

    sequence s_sample_start;
        state == ST_SAMPLE && conversion_start && powered;
    endsequence

    sequence s_chop_muted;
        state == ST_CONVERT && ctrl.chop_enable && muted_mid
        ##1 state == ST_CHOP2 && muted_mid;
    endsequence

    a_start_sets: // see [R07]
    assert property (start_write && state != ST_OFF |=> conversion_start)
        else $error("start write not held in start bit");

    a_start_clears: // see [R08]
    assert property (done && !start_write |=> !conversion_start)
        else $error("start bit not cleared on completion");

    a_conv_one_cycle: // see [R09]
    assert property (s_sample_start ##1 !ctrl.chop_enable
                     |=> result_ready && state != ST_CONVERT)
        else $error("conversion did not end in one cycle");

    a_chop_pair: // see [R12]
    assert property (s_chop_pair |=> result_ready)
        else $error("chop pair did not complete");

    a_mute_mid: // see [R14]
    assert property (state == ST_CONVERT && !ctrl.chop_enable
                     && ctrl.input_mute_midscale && !ctrl.polarity_invert
                     && ctrl.positive_offset_trim == CODE_MID
                     |=> conversion_result == CODE_MID)
        else $error("muted result not at mid-scale");

    a_invert_mid: // see [R15]
    assert property (state == ST_CONVERT && !ctrl.chop_enable
                     && ctrl.input_mute_midscale && ctrl.polarity_invert
                     && ctrl.negative_offset_trim == CODE_MID
                     |=> conversion_result == CODE_MAX - CODE_MID)
        else $error("inverted muted result not below mid-scale");

    a_result_hold: // see [R19]
    assert property (!done |=> $stable(conversion_result))
        else $error("result changed without a conversion");

    a_sample_load: // see [R11]
    assert property (sampling_load_on |-> state == ST_SAMPLE
                     && !converter_hold)
        else $error("sampling load outside sampling phase");

    a_track_off: // see [R06]
    assert property (!ctrl.converter_enable |=> !sampling_active
                     && !converter_hold)
        else $error("tracking while converter disabled");

    a_battery_attn: // see [R03]
    assert property (ctrl.channel_select == CH_BATTERY |-> attenuator_on)
        else $error("battery channel without attenuator");

    a_settle_time: // see [R05]
    assert property ($rose(ctrl.converter_regulator_enable)
                     |-> !regulator_settled [*8])
        else $error("regulator reported settled too early");

    a_off_idle: // see [R06]
    assert property (state == ST_OFF |-> !sampling_active
                     && !converter_hold && !sampling_load_on)
        else $error("active while off");

    a_power_drop: // see [R06]
    assert property (!powered |=> state == ST_OFF)
        else $error("not off after disable");

    a_off_clear: // see [R08]
    assert property (state == ST_OFF |=> !conversion_start)
        else $error("start bit kept while off");

    a_sample_wait: // see [R07]
    assert property (state == ST_SAMPLE && !conversion_start
                     |=> state != ST_CONVERT)
        else $error("conversion without start");

    a_conv_exit: // see [R08]
    assert property (state == ST_CONVERT && !ctrl.chop_enable && powered
                     |=> state == ST_SAMPLE)
        else $error("no return to sampling");

    a_chop_exit: // see [R12]
    assert property (second_half && powered |=> state == ST_SAMPLE)
        else $error("no return after chop");

    a_ready_pulse: // see [R09]
    assert property (result_ready |=> !result_ready)
        else $error("ready pulse too long");

    a_chop_mute: // see [R12]
    assert property (s_chop_muted
                     |=> conversion_result == CODE_MAX - CODE_MID)
        else $error("muted chop not 1FF");

    a_load_follow: // see [R11]
    assert property (sampling_active && ctrl.sampling_dummy_load
                     |-> sampling_load_on)
        else $error("sampling load missing");

    a_const_load: // see [R10]
    assert property (ctrl.constant_dummy_load
                     && ctrl.converter_regulator_enable |-> constant_load_on)
        else $error("constant load missing");

    a_settle_keep: // see [R05]
    assert property (regulator_settled && ctrl.converter_regulator_enable
                     |=> regulator_settled)
        else $error("settled status lost");

    a_settle_drop: // see [R05]
    assert property (!ctrl.converter_regulator_enable |=> !regulator_settled)
        else $error("settled while disabled");

    a_mux_single: // see [R01]
    assert property (ctrl.single_ended_select |-> single_ended)
        else $error("single-ended ignored");

    a_mux_pair: // see [R02]
    assert property (!ctrl.single_ended_select
                     && ctrl.channel_select <= CH_PIN3 |-> !single_ended)
        else $error("pair not differential");
endmodule
`default_nettype wire

//--- design/gac_pkg.sv
/*
 * Package of the converter control block: constants, channel codes,
 * state encoding and the control carrier struct.
 * Assumes one 20 MHz clock and analog levels given as 12-bit codes,
 * where 1023 stands for the 1.2 V reference.
 */
// Summary of operation
// [R01] One bit selects single-ended or differential conversion.
// [R02] Mux routes one of four pins, or one of two fixed pin pairs.
// [R03] Mux can also select battery or internal monitor voltages.
// [R04] Attenuator bit triples the input scale in both modes.
// [R05] Software enables the regulator and waits for it to settle.
// [R06] While the converter is enabled, the selected input is tracked.
// [R07] Writing one to start ends sampling and begins conversion.
// [R08] On completion the start bit clears itself and sampling resumes.
// [R09] Conversion takes one clock cycle.
// [R10] Constant dummy load keeps regulator current above zero.
// [R11] Dynamic dummy load is applied only during sampling.
// [R12] Chop takes two samples of opposite polarity and averages them.
// [R13] Natural zero point is mid-scale, between 1FF and 200 hex.
// [R14] Mute switches the input to mid-scale to expose output offset.
// [R15] Sign bit inverts input and output, reversing offset sign.
// [R16] Software may sum opposite-sign results and drop the LSB.
// [R17] Positive and negative offset trims compensate comparator offset.
// [R18] Software calibrates with trims at mid-scale, mute on, sign off.
// [R19] Result register updates when the start bit clears.
package gac_pkg;
    localparam int CODE_W = 10;
    localparam int LEVEL_W = 12;
    localparam int CALC_W = 14;
    localparam int ATTN_RATIO = 3;

    localparam logic [CODE_W-1:0] CODE_MID = 10'h200;
    localparam logic [CODE_W-1:0] CODE_MAX = 10'h3FF;
    localparam logic [CODE_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [LEVEL_W-1:0] ZERO_SE = 12'h200;
    localparam logic [LEVEL_W-1:0] ZERO_SE_ATTN = 12'h600;
    localparam logic [CALC_W-1:0] TRIM_BIAS = 14'h0400;

    localparam int CLK_PERIOD_NS = 50;
    localparam int SETTLE_TIME_NS = 20000;
    localparam int SETTLE_CYCLES =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
    localparam int N_PINS = 4;
    localparam int N_INTERNAL = 3;

    localparam logic [2:0] CH_PIN0 = 3'h0;
    localparam logic [2:0] CH_PIN3 = 3'h3;
    localparam logic [2:0] CH_BATTERY = 3'h4;
    localparam logic [2:0] CH_INT_BASE = 3'h5;

    typedef logic [LEVEL_W-1:0] gac_level_t;

    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b10,
        ST_CHOP2   = 2'b11
    } gac_state_t;

    typedef struct packed {
        logic              single_ended_select;
        logic              triple_scale_attenuator;
        logic              converter_regulator_enable;
        logic              converter_enable;
        logic              constant_dummy_load;
        logic              sampling_dummy_load;
        logic              chop_enable;
        logic              input_mute_midscale;
        logic              polarity_invert;
        logic [2:0]        channel_select;
        logic [CODE_W-1:0] positive_offset_trim;
        logic [CODE_W-1:0] negative_offset_trim;
    } gac_ctrl_t;
endpackage

//--- design/gac_input_mux.sv
/*
 * Input multiplexer of the converter: picks the positive and negative
 * levels and the effective attenuator setting.
 * Assumes levels from pins and monitors are stable while sampled.
 */
`timescale 1ns/1ps
`default_nettype none
module gac_input_mux
    import gac_pkg::*;
(
    input  wire gac_ctrl_t  ctrl,
    input  wire gac_level_t pin_level [N_PINS],
    input  wire gac_level_t battery_level,
    input  wire gac_level_t internal_level [N_INTERNAL],
    output logic [LEVEL_W-1:0] pos_level,
    output logic [LEVEL_W-1:0] neg_level,
    output logic               single_ended,
    output logic               attenuate
);
    logic [2:0] int_index;
    logic [1:0] pair_base;

    assign int_index = ctrl.channel_select - CH_INT_BASE;
    assign pair_base = {ctrl.channel_select[0], 1'b0};

    always_comb begin
        pos_level = battery_level;
        neg_level = '0;
        single_ended = 1'b1;
        attenuate = ctrl.triple_scale_attenuator; // see [R04]
        if (ctrl.channel_select <= CH_PIN3) begin
            if (ctrl.single_ended_select) begin // see [R01]
                pos_level = pin_level[ctrl.channel_select[1:0]]; // see [R02]
            end else begin
                single_ended = 1'b0;
                pos_level = pin_level[pair_base]; // see [R02]
                neg_level = pin_level[pair_base + 2'd1];
            end
        end else if (ctrl.channel_select == CH_BATTERY) begin
            attenuate = 1'b1; // see [R03]
        end else begin
            pos_level = internal_level[int_index[1:0]]; // see [R03]
        end
    end
endmodule
`default_nettype wire

//--- design/gac_convert_core.sv
/*
 * Arithmetic model of one conversion: scale, mute, sign and offset
 * trim, saturated to the 10-bit code range.
 * Assumes inputs settle within one clock cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module gac_convert_core
    import gac_pkg::*;
(
    input  wire logic [LEVEL_W-1:0] pos_level,
    input  wire logic [LEVEL_W-1:0] neg_level,
    input  wire logic               single_ended,
    input  wire logic               attenuate,
    input  wire logic               mute,
    input  wire logic               invert,
    input  wire logic [CODE_W-1:0]  trim,
    output logic [CODE_W-1:0]       code
);
    logic signed [CALC_W-1:0] pos_s;
    logic signed [CALC_W-1:0] neg_s;
    logic signed [CALC_W-1:0] signal;
    logic signed [CALC_W-1:0] scaled;
    logic signed [CALC_W-1:0] level;
    logic [CODE_W-1:0]        clamped;

    assign pos_s = $signed({2'b00, pos_level});
    assign neg_s = $signed({2'b00, neg_level});

    always_comb begin
        if (single_ended) begin // see [R01]
            signal = pos_s - $signed({2'b00,
                         attenuate ? ZERO_SE_ATTN : ZERO_SE});
        end else begin
            signal = (pos_s - neg_s) >>> 1;
        end
        scaled = attenuate ? CALC_W'(signal / ATTN_RATIO)
                           : signal; // see [R04]
        if (mute) begin
            scaled = '0; // see [R14]
        end
        if (invert) begin
            scaled = -scaled; // see [R15]
        end
        // Trim at mid-scale leaves the natural zero at 200 hex
        level = scaled + $signed(TRIM_BIAS)
              - $signed({4'h0, trim}); // see [R13] see [R17]
        if (level < 0) begin
            clamped = '0;
        end else if (level > $signed({4'h0, CODE_MAX})) begin
            clamped = CODE_MAX;
        end else begin
            clamped = level[CODE_W-1:0];
        end
        code = invert ? CODE_MAX - clamped : clamped; // see [R15]
    end
endmodule
`default_nettype wire

//--- verification/gac_source_model.sv
/*
 * Far-side model: fixed level codes on the four pins, the battery
 * and the internal monitors.
 * Assumes the 12-bit level scale of gac_pkg.
 */
`timescale 1ns/1ps
`default_nettype none
module gac_source_model
    import gac_pkg::*;
(
    output var gac_level_t pin_level      [N_PINS],
    output var gac_level_t battery_level,
    output var gac_level_t internal_level [N_INTERNAL]
);
    // Multiples of three keep scaled codes exact
    always_comb begin
        pin_level[0]      = 12'h300;
        pin_level[1]      = 12'h102;
        pin_level[2]      = 12'h0A2;
        pin_level[3]      = 12'h1C2;
        battery_level     = 12'h750;
        internal_level[0] = 12'h180;
        internal_level[1] = 12'h2A0;
        internal_level[2] = 12'h3F0;
    end
endmodule
`default_nettype wire

//--- verification/tb.sv
/*
 * Self-checking bench of the converter control block.
 * Assumes gac_source_model drives the analog levels.
 */
`timescale 1ns/1ps
`default_nettype none
module tb
    import gac_pkg::*;
;
    logic              clock;
    logic              reset;
    logic              start_write;
    gac_ctrl_t         ctrl;
    gac_ctrl_t         c2;
    gac_level_t        pin_lv [N_PINS];
    gac_level_t        bat_lv;
    gac_level_t        int_lv [N_INTERNAL];
    logic              conversion_start;
    logic              result_ready;
    logic              regulator_settled;
    logic              sampling_active;
    logic              converter_hold;
    logic              constant_load_on;
    logic              sampling_load_on;
    logic              attenuator_on;
    logic [CODE_W-1:0] conversion_result;
    logic [CODE_W-1:0] r;
    logic [CODE_W-1:0] a;
    int                e;
    int                error_cnt = 0;
    int                comparisons = 0;

    gac_source_model gac_source_model_i (
        .pin_level(pin_lv), .battery_level(bat_lv), .internal_level(int_lv));
    gac_control gac_control_i (
        .clock(clock), .reset(reset), .ctrl(ctrl),
        .start_write(start_write), .pin_level(pin_lv),
        .battery_level(bat_lv), .internal_level(int_lv),
        .conversion_start(conversion_start),
        .conversion_result(conversion_result),
        .result_ready(result_ready),
        .regulator_settled(regulator_settled),
        .sampling_active(sampling_active),
        .converter_hold(converter_hold),
        .constant_load_on(constant_load_on),
        .sampling_load_on(sampling_load_on),
        .attenuator_on(attenuator_on));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (!ok) begin
            error_cnt++;
            $display("[FAIL] %0t ns: %s", $time, msg);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Expected code from the level model
    function automatic int expect_code(gac_ctrl_t c);
        int   p;
        int   n;
        int   v;
        int   code;
        logic att;
        att = c.triple_scale_attenuator | (c.channel_select == CH_BATTERY);
        n = 0;
        if (c.channel_select == CH_BATTERY) begin
            p = bat_lv;
        end else if (c.channel_select >= CH_INT_BASE) begin
            p = int_lv[int'(c.channel_select - CH_INT_BASE)];
        end else if (c.single_ended_select) begin
            p = pin_lv[c.channel_select[1:0]];
        end else begin
            p = pin_lv[{c.channel_select[0], 1'b0}];
            n = pin_lv[{c.channel_select[0], 1'b1}];
        end
        if (c.input_mute_midscale) begin
            v = 0;
        end else if (c.single_ended_select) begin
            v = att ? (p - int'(ZERO_SE_ATTN)) / 3 : p - int'(ZERO_SE);
        end else begin
            v = att ? (p - n) / 6 : (p - n) / 2;
        end
        if (c.polarity_invert) begin
            code = 1024 - v - int'(c.negative_offset_trim);
        end else begin
            code = 1024 + v - int'(c.positive_offset_trim);
        end
        code = (code < 0) ? 0 : ((code > 1023) ? 1023 : code);
        return c.polarity_invert ? 1023 - code : code;
    endfunction

    // One conversion, walked cycle by cycle
    task automatic conv(output logic [CODE_W-1:0] res);
        start_write = 1'b1;
        @(negedge clock);
        start_write = 1'b0;
        chk(conversion_start === 1'b1, "start bit not set");
        @(negedge clock);
        chk(converter_hold === 1'b1 && sampling_active === 1'b0 &&
            sampling_load_on === 1'b0,
            "no conversion phase");
        if (ctrl.chop_enable) begin
            @(negedge clock);
            chk(converter_hold === 1'b1, "no second chop phase");
        end
        @(negedge clock);
        chk(result_ready === 1'b1 && conversion_start === 1'b0 &&
            sampling_active === 1'b1,
            "no completion");
        chk(sampling_load_on === ctrl.sampling_dummy_load,
            "sampling load wrong");
        res = conversion_result;
        @(negedge clock);
        chk(result_ready === 1'b0, "ready not a pulse");
    endtask

    task automatic t_power;
        chk(conversion_start === 1'b0 && conversion_result === RESULT_RESET
            && regulator_settled === 1'b0, "reset state");
        ctrl.constant_dummy_load = 1'b1;
        start_write = 1'b1;
        @(negedge clock);
        start_write = 1'b0;
        @(negedge clock);
        chk(conversion_start === 1'b0 && constant_load_on === 1'b0,
            "active while off");
        ctrl.converter_regulator_enable = 1'b1;
        ctrl.converter_enable = 1'b1;
        ctrl.sampling_dummy_load = 1'b1;
        repeat (2) @(negedge clock);
        chk(sampling_active === 1'b1 && constant_load_on === 1'b1 &&
            sampling_load_on === 1'b1,
            "not sampling");
        repeat (385) @(negedge clock);
        chk(regulator_settled === 1'b0, "settled early");
        repeat (20) @(negedge clock);
        chk(regulator_settled === 1'b1, "never settled");
        $display("Test power done");
    endtask

    task automatic t_channels;
        for (int se = 0; se < 2; se++) begin
            for (int at = 0; at < 2; at++) begin
                for (int ch = 0; ch < 8; ch++) begin
                    if (se == 0 && ch > 1) begin
                        continue;
                    end
                    ctrl.single_ended_select = se[0];
                    ctrl.triple_scale_attenuator = at[0];
                    ctrl.channel_select = ch[2:0];
                    @(negedge clock);
                    chk(attenuator_on === (at[0] | (ch == 4)),
                        "attenuator wrong");
                    conv(r);
                    chk(r === CODE_W'(expect_code(ctrl)),
                        "channel result");
                end
            end
        end
        ctrl.channel_select = CH_PIN0;
        ctrl.triple_scale_attenuator = 1'b0;
        $display("Test channels done");
    endtask

    task automatic t_offset;
        ctrl.input_mute_midscale = 1'b1;
        conv(a);
        chk(a === CODE_MID, "muted result");
        ctrl.polarity_invert = 1'b1;
        conv(r);
        chk(r === 10'h1FF, "inverted muted result");
        chk(11'(a) + 11'(r) === 11'h3FF, "sum not midscale");
        ctrl.negative_offset_trim = 10'h1F0;
        conv(r);
        chk(r === 10'h1EF, "negative trim");
        ctrl.polarity_invert = 1'b0;
        ctrl.positive_offset_trim = 10'h210;
        conv(r);
        chk(r === 10'h1F0, "positive trim");
        ctrl.input_mute_midscale = 1'b0;
        ctrl.positive_offset_trim = 10'h000;
        conv(r);
        chk(r === CODE_MAX, "no saturation");
        ctrl.positive_offset_trim = CODE_MID;
        ctrl.negative_offset_trim = CODE_MID;
        $display("Test offset done");
    endtask

    task automatic t_chop;
        ctrl.chop_enable = 1'b1;
        for (int m = 0; m < 2; m++) begin
            ctrl.input_mute_midscale = m[0];
            c2 = ctrl;
            c2.polarity_invert = 1'b0;
            e = expect_code(c2);
            c2.polarity_invert = 1'b1;
            e = (e + expect_code(c2)) >> 1;
            conv(r);
            chk(r === CODE_W'(e), "chop average");
        end
        ctrl.chop_enable = 1'b0;
        ctrl.input_mute_midscale = 1'b0;
        $display("Test chop done");
    endtask

    task automatic t_order;
        start_write = 1'b1;
        @(negedge clock);
        start_write = 1'b0;
        @(negedge clock);
        start_write = 1'b1;
        @(negedge clock);
        start_write = 1'b0;
        chk(conversion_start === 1'b1 && result_ready === 1'b1,
            "restart lost");
        @(negedge clock);
        chk(converter_hold === 1'b1, "no second conversion");
        @(negedge clock);
        chk(result_ready === 1'b1 && conversion_start === 1'b0,
            "second not done");
        start_write = 1'b1;
        @(negedge clock);
        start_write = 1'b0;
        ctrl.converter_enable = 1'b0;
        @(negedge clock);
        chk(sampling_active === 1'b0 && result_ready === 1'b0,
            "abort failed");
        @(negedge clock);
        chk(conversion_start === 1'b0 && result_ready === 1'b0,
            "result after abort");
        ctrl.converter_enable = 1'b1;
        repeat (2) @(negedge clock);
        $display("Test order done");
    endtask

    initial begin
        #(300_000);
        error_cnt++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        final_report();
    end

    initial begin
        reset = 1'b1;
        start_write = 1'b0;
        ctrl = '0;
        ctrl.positive_offset_trim = CODE_MID;
        ctrl.negative_offset_trim = CODE_MID;
        ctrl.single_ended_select = 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        t_power();
        t_channels();
        t_offset();
        t_chop();
        t_order();
        final_report();
    end
endmodule
`default_nettype wire
